// File: rtcc_access_regs.svh
// register offsets, field masks and bus constants of the clock/SRAM access block
`ifndef RTCC_ACCESS_REGS_SVH
`define RTCC_ACCESS_REGS_SVH

// shared 7-bit target address of clock registers and SRAM
`define CTRL_ADDR   7'h6f

// address map and pointer wrap points
`define REG_FIRST   7'h00
`define REG_LAST    7'h1f
`define SRAM_FIRST  7'h20
`define SRAM_LAST   7'h5f

// register offsets inside the clock block
`define STATUS_OFS  5'h03
`define DN_MIN_OFS  5'h18
`define DN_HOUR_OFS 5'h19
`define DN_DATE_OFS 5'h1a
`define DN_MTH_OFS  5'h1b
`define UP_MIN_OFS  5'h1c
`define UP_HOUR_OFS 5'h1d
`define UP_DATE_OFS 5'h1e
`define UP_MTH_OFS  5'h1f
`define STAMP_SEL   5'h18

// implemented bits of each register, the rest read as zero except status bits 5 and 4
`define MASK_MIN    8'h7f
`define MASK_HOUR   8'h7f
`define MASK_DATE   8'h3f
`define MASK_MTH    8'hff
`define MASK_STATUS 8'h0f
`define MASK_FULL   8'hff

// status register fields
`define ST_OSC_BIT  5
`define ST_PF_BIT   4
`define ST_BEN_BIT  3

// bit counts within one byte on the bus
`define CNT_BYTE    4'h8
`define CNT_ACK     4'h9

`endif

// File: rtcc_access_pkg.sv
// types shared by the clock/SRAM bus access block
`default_nettype none
package rtcc_access_pkg;
    // transfer phase of the serial target
    typedef enum {
        ST_IDLE,
        ST_CTRL,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_SKIP
    } bus_state_t;

    // byte address covering registers and SRAM
    typedef logic [6:0] addr_t;
endpackage : rtcc_access_pkg
`default_nettype wire

// File: rtcc_sram_i2c_access.sv
// serial target giving access to clock registers, time stamps and general SRAM
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_access_regs.svh"

module rtcc_sram_i2c_access #(
    parameter int SRAM_DEPTH = 64
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // serial bus pins, open drain data
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // supply state pin
    input  wire logic       on_backup,
    // current time and power events from the timekeeper
    input  wire logic [7:0] now_minutes,
    input  wire logic [7:0] now_hours,
    input  wire logic [7:0] now_date,
    input  wire logic [7:0] now_month,
    input  wire logic       capture_down,
    input  wire logic       capture_up,
    input  wire logic       oscillator_running_flag,
    // status towards the rest of the chip
    output logic            power_fail_flag,
    output logic            backup_input_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the SRAM window in the address map is fixed at 64 bytes
    if (SRAM_DEPTH != 64) begin : g_bad_depth
        $error("SRAM_DEPTH must match the 64-byte SRAM window");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                        scl_s1_r;    // scl first sync stage
    logic                        scl_s2_r;    // scl synchronised
    logic                        scl_d_r;     // scl one cycle later
    logic                        sda_s1_r;    // sda first sync stage
    logic                        sda_s2_r;    // sda synchronised
    logic                        sda_d_r;     // sda one cycle later
    logic                        bak_s1_r;    // backup pin first stage
    logic                        bak_s2_r;    // backup pin synchronised
    logic                        scl_rise;    // rising edge of bus clock
    logic                        scl_fall;    // falling edge of bus clock
    logic                        start_det;   // start or repeated start
    logic                        stop_det;    // stop condition
    rtcc_access_pkg::bus_state_t state_r;     // transfer phase
    logic [3:0]                  bit_cnt_r;   // clock count within byte
    logic [7:0]                  shift_r;     // received byte
    logic [7:0]                  tx_r;        // byte being sent
    logic                        sda_oe_r;    // pulling data low
    logic                        rw_r;        // direction bit of control byte
    logic                        mack_r;      // controller acked last byte
    rtcc_access_pkg::addr_t      ptr_r;
    logic                        wr_en;       // data byte accepted
    logic                        wr_reg;      // write into clock block
    logic                        wr_sram;     // write into SRAM block
    logic                        pf_clear;    // software clears fail flag
    logic                        pf_r;        // power fail flag
    logic                        pend_up_r;   // waiting for power-up capture
    logic [7:0]                  rd_byte;     // byte at the pointer
    logic [7:0]                  regs_r [0:31];            // clock block
    logic [7:0]                  sram_r [0:SRAM_DEPTH-1];  // general SRAM
    logic [5:0]                  sram_idx;    // SRAM word index

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // next pointer value, wrapping within its block
    function automatic rtcc_access_pkg::addr_t next_addr(input rtcc_access_pkg::addr_t a);
        if (a == `REG_LAST) begin
            next_addr = `REG_FIRST;
        end else if (a == `SRAM_LAST) begin
            next_addr = `SRAM_FIRST;
        end else begin
            next_addr = a + 7'h01;
        end
    endfunction : next_addr

    // implemented bits of a clock-block location
    function automatic logic [7:0] field_mask(input logic [4:0] ofs);
        field_mask = `MASK_FULL;
        if (ofs == `STATUS_OFS) begin
            field_mask = `MASK_STATUS;
        end else if ((ofs & `STAMP_SEL) == `STAMP_SEL) begin
            unique case (ofs[1:0])
                2'h0: field_mask = `MASK_MIN;
                2'h1: field_mask = `MASK_HOUR;
                2'h2: field_mask = `MASK_DATE;
                2'h3: field_mask = `MASK_MTH;
            endcase
        end
    endfunction : field_mask

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // pins pass two flops; the third flop only serves edge detection
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
            bak_s1_r <= 1'b0;
            bak_s2_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
            bak_s1_r <= on_backup;
            bak_s2_r <= bak_s1_r;
        end
    end

    // bus events from synchronised levels
    assign scl_rise  = scl_s2_r & ~scl_d_r;
    assign scl_fall  = ~scl_s2_r & scl_d_r;
    assign start_det = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
    assign stop_det  = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // serial target state machine

    // acks and data change on scl falling edges, input sampled on rising
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= rtcc_access_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            tx_r      <= 8'h00;
            sda_oe_r  <= 1'b0;
            rw_r      <= 1'b0;
            mack_r    <= 1'b0;
            ptr_r     <= `REG_FIRST;
        end else if (bak_s2_r) begin
            // on backup the bus is ignored and released
            state_r   <= rtcc_access_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end else if (start_det) begin
            state_r   <= rtcc_access_pkg::ST_CTRL;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end else if (stop_det) begin
            // stop ends any transfer and releases data
            state_r   <= rtcc_access_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end else if (state_r != rtcc_access_pkg::ST_IDLE && state_r != rtcc_access_pkg::ST_SKIP) begin
            if (scl_rise) begin
                if (bit_cnt_r < `CNT_BYTE) begin
                    shift_r <= {shift_r[6:0], sda_s2_r};
                end else begin
                    mack_r <= ~sda_s2_r;
                end
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == `CNT_BYTE) begin
                // byte complete: decide the acknowledge
                unique case (state_r)
                    rtcc_access_pkg::ST_CTRL: begin
                        if (shift_r[7:1] == `CTRL_ADDR) begin
                            sda_oe_r <= 1'b1;
                            rw_r     <= shift_r[0];
                        end else begin
                            state_r <= rtcc_access_pkg::ST_SKIP;
                        end
                    end
                    rtcc_access_pkg::ST_ADDR: begin
                        if (shift_r <= {1'b0, `SRAM_LAST}) begin
                            sda_oe_r <= 1'b1;
                            ptr_r    <= shift_r[6:0];
                        end else begin
                            state_r <= rtcc_access_pkg::ST_SKIP;
                        end
                    end
                    rtcc_access_pkg::ST_WDATA: begin
                        // no count limit; the pointer just wraps
                        sda_oe_r <= 1'b1;
                        ptr_r    <= next_addr(ptr_r);
                    end
                    rtcc_access_pkg::ST_RDATA: begin
                        sda_oe_r <= 1'b0; // let the controller answer
                    end
                    rtcc_access_pkg::ST_IDLE, rtcc_access_pkg::ST_SKIP: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end else if (scl_fall && bit_cnt_r == `CNT_ACK) begin
                // acknowledge clock over: release and move on
                bit_cnt_r <= 4'h0;
                sda_oe_r  <= 1'b0;
                if (state_r == rtcc_access_pkg::ST_CTRL && rw_r) begin
                    state_r  <= rtcc_access_pkg::ST_RDATA;
                    tx_r     <= rd_byte;
                    sda_oe_r <= ~rd_byte[7];
                    ptr_r    <= next_addr(ptr_r);
                end else if (state_r == rtcc_access_pkg::ST_CTRL) begin
                    state_r <= rtcc_access_pkg::ST_ADDR;
                end else if (state_r == rtcc_access_pkg::ST_ADDR) begin
                    state_r <= rtcc_access_pkg::ST_WDATA;
                end else if (state_r == rtcc_access_pkg::ST_RDATA && mack_r) begin
                    // controller asked for more: next byte
                    tx_r     <= rd_byte;
                    sda_oe_r <= ~rd_byte[7];
                    ptr_r    <= next_addr(ptr_r);
                end else if (state_r == rtcc_access_pkg::ST_RDATA) begin
                    state_r <= rtcc_access_pkg::ST_SKIP;
                end
            end else if (scl_fall && state_r == rtcc_access_pkg::ST_RDATA) begin
                // shift out the next data bit
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
            end
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_r;

    ////////////////////////////////////////////////////////////////////////////
    // write strobes and read mux

    // must mirror the priority of the state machine above
    assign wr_en    = state_r == rtcc_access_pkg::ST_WDATA && scl_fall && bit_cnt_r == `CNT_BYTE
                      && !start_det && !stop_det && !bak_s2_r;
    assign wr_reg   = wr_en && ptr_r <= `REG_LAST;
    assign wr_sram  = wr_en && ptr_r >= `SRAM_FIRST;
    assign sram_idx = 6'(ptr_r - `SRAM_FIRST);
    assign pf_clear = wr_reg && ptr_r[4:0] == `STATUS_OFS && !shift_r[`ST_PF_BIT];

    // byte at the pointer; unimplemented bits read as zero
    always_comb begin
        rd_byte = regs_r[ptr_r[4:0]] & field_mask(ptr_r[4:0]);
        if (ptr_r >= `SRAM_FIRST) begin
            rd_byte = sram_r[sram_idx];
        end else if (ptr_r[4:0] == `STATUS_OFS) begin
            rd_byte[`ST_OSC_BIT] = oscillator_running_flag;
            rd_byte[`ST_PF_BIT]  = pf_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock block registers and time stamps

    // later statements win: a down capture beats a clear in the same cycle, an up capture is dropped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) begin
                regs_r[i] <= 8'h00;
            end
            pf_r      <= 1'b0;
            pend_up_r <= 1'b0;
        end else begin
            if (wr_reg) begin
                regs_r[ptr_r[4:0]] <= shift_r & field_mask(ptr_r[4:0]);
            end
            if (pf_clear) begin
                pf_r      <= 1'b0;
                pend_up_r <= 1'b0;
                for (int i = 0; i < 8; i++) begin
                    regs_r[`DN_MIN_OFS + 5'(i)] <= 8'h00;
                end
            end
            if (capture_down && (!pf_r || pf_clear)) begin
                regs_r[`DN_MIN_OFS]  <= now_minutes & `MASK_MIN;
                regs_r[`DN_HOUR_OFS] <= now_hours & `MASK_HOUR;
                regs_r[`DN_DATE_OFS] <= now_date & `MASK_DATE;
                regs_r[`DN_MTH_OFS]  <= now_month & `MASK_MTH;
                pf_r      <= 1'b1;
                pend_up_r <= 1'b1;
            end
            // power-up stamp only completes a pending power-down record
            if (capture_up && pend_up_r && !pf_clear) begin
                regs_r[`UP_MIN_OFS]  <= now_minutes & `MASK_MIN;
                regs_r[`UP_HOUR_OFS] <= now_hours & `MASK_HOUR;
                regs_r[`UP_DATE_OFS] <= now_date & `MASK_DATE;
                regs_r[`UP_MTH_OFS]  <= now_month & `MASK_MTH;
                pend_up_r <= 1'b0;
            end
        end
    end

    // status outputs from flops
    assign power_fail_flag     = pf_r;
    assign backup_input_enable = regs_r[`STATUS_OFS][`ST_BEN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // general SRAM

    // no reset: contents survive power-on reset
    always_ff @(posedge clock) begin
        if (wr_sram) begin
            sram_r[sram_idx] <= shift_r;
        end
    end

endmodule : rtcc_sram_i2c_access

`default_nettype wire

// File: rtcc_access_assertions.sv
// pin-level checker of the clock and SRAM bus access block
`timescale 1ns/1ns
`default_nettype none

module rtcc_access_check (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus and supply pins
    input wire logic scl_in,
    input wire logic sda_oe,
    input wire logic on_backup,
    // capture event and status
    input wire logic capture_down,
    input wire logic power_fail_flag,
    input wire logic backup_input_enable
);
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////
    // pins and status come out of reset quiet
    a_reset_quiet: assert property ($rose(rst_n) |-> !sda_oe && !power_fail_flag)
        else $error("pins not quiet after reset");
    // backup supply held four clocks: the target no longer pulls the data line
    a_backup_no_drive: assert property (on_backup [*4] |-> !sda_oe)
        else $error("data driven on backup supply");
    // ack and read bits start only while the bus clock is low
    a_drive_on_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data drive began with bus clock high");
    // whatever the target drives stands through the high phase
    a_hold_high: assert property ($rose(scl_in) |=> $stable(sda_oe) [*3])
        else $error("data drive changed while bus clock high");
    // the target lets go of the line in bounded time
    a_drive_released: assert property ($rose(sda_oe) |-> ##[1:300] !sda_oe)
        else $error("data line held too long");
    // written bits land during the acknowledge
    a_store_in_ack: assert property ($changed(backup_input_enable) |-> sda_oe)
        else $error("status changed outside acknowledge");
    // a down event with the flag clear sets it next clock
    a_capture_flag: assert property (capture_down && !power_fail_flag |=> power_fail_flag)
        else $error("power fail flag not set by capture");
    // only a down event can raise the flag
    a_flag_cause: assert property ($rose(power_fail_flag) |-> $past(capture_down))
        else $error("power fail flag rose without capture");
    // only a bus write, stored during its ack, clears the flag
    a_flag_clear: assert property ($fell(power_fail_flag) |-> sda_oe)
        else $error("power fail flag cleared outside write");

    // main scenarios reached
    c_ack: cover property ($rose(sda_oe));
    c_capture_blocked: cover property (capture_down && power_fail_flag);
    c_flag_cleared: cover property ($fell(power_fail_flag));
endmodule : rtcc_access_check

bind rtcc_sram_i2c_access rtcc_access_check chk (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe), .on_backup(on_backup),
    .capture_down(capture_down), .power_fail_flag(power_fail_flag),
    .backup_input_enable(backup_input_enable)
);

`default_nettype wire

// File: bus_ctl_model.sv
// serial bus controller model: bus clock and open-drain data
`timescale 1ns/1ns
`default_nettype none

module bus_ctl_model (
    // pacing clock
    input  wire logic clock,
    // resolved data wire
    input  wire logic sda_line,
    // driven pins
    output var logic  scl,
    output var logic  sda_low
);
    // idle bus: clock stands high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // one half of the 160 ns bus clock
    task automatic half;
        repeat (4) @(posedge clock);
    endtask : half

    // one bit: data moves a clock after the fall, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        @(posedge clock);
        sda_low <= !b;
        // low phase is four clocks in all, keeping the bit at 160 ns
        repeat (3) @(posedge clock);
        scl <= 1'b1;
        half();
        r = sda_line;
        scl <= 1'b0;
    endtask : bit_io

    // one byte msb first, ninth bit is ours to release or pull
    task automatic xbyte(input logic [7:0] d, input logic last, output logic ack, output logic [7:0] r);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            r[i] = s;
        end
        bit_io(last, s);
        ack = !s;
    endtask : xbyte

    // data falls while clock is high
    task automatic start;
        @(posedge clock);
        sda_low <= 1'b1;
        half();
        scl <= 1'b0;
    endtask : start

    // data rises while clock is high, then the bus rests
    task automatic stop;
        @(posedge clock);
        sda_low <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_low <= 1'b0;
        half();
    endtask : stop
endmodule : bus_ctl_model

`default_nettype wire

// File: rtcc_sram_i2c_access_tb.sv
// self-checking bench of the clock and SRAM bus access block
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_access_regs.svh"

module rtcc_sram_i2c_access_tb;
    logic       clock;
    logic       rst_n;
    logic       on_backup;
    logic       capture_down;
    logic       capture_up;
    logic [7:0] now_minutes;
    logic [7:0] now_hours;
    logic [7:0] now_date;
    logic [7:0] now_month;
    logic [7:0] wbuf [16];
    logic [7:0] ebuf [16];
    logic [7:0] rbuf [16];
    logic       ack;
    int         err_count;
    int         n_compared;
    int         cycles;
    wire logic  scl, sda_low, sda_line, sda_out, sda_oe, power_fail_flag, backup_input_enable;

    // open-drain wire with pull-up
    assign sda_line = !(sda_oe && !sda_out) && !sda_low;

    bus_ctl_model ctl (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    rtcc_sram_i2c_access #(.SRAM_DEPTH(64)) DUT (
        .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .on_backup(on_backup), .now_minutes(now_minutes), .now_hours(now_hours),
        .now_date(now_date), .now_month(now_month), .capture_down(capture_down),
        .capture_up(capture_up), .oscillator_running_flag(1'b1),
        .power_fail_flag(power_fail_flag), .backup_input_enable(backup_input_enable));

    ////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // compare one bit-wide result
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // compare one byte read back
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    // write n bytes of wbuf from address a; n of zero only loads the pointer
    task automatic wr(input logic [7:0] a, input int n);
        logic [7:0] d;
        ctl.start();
        ctl.xbyte({`CTRL_ADDR, 1'b0}, 1'b1, ack, d);
        chk_bit(ack, 1'b1);
        ctl.xbyte(a, 1'b1, ack, d);
        chk_bit(ack, 1'(a <= 8'h5f));
        for (int i = 0; i < n; i++) begin
            ctl.xbyte(wbuf[i], 1'b1, ack, d);
            chk_bit(ack, 1'(a <= 8'h5f));
        end
        ctl.stop();
    endtask : wr

    // current-address read of n bytes; the last one is not acknowledged
    task automatic rd(input int n);
        logic [7:0] d;
        ctl.start();
        ctl.xbyte({`CTRL_ADDR, 1'b1}, 1'b1, ack, d);
        chk_bit(ack, 1'b1);
        for (int i = 0; i < n; i++) ctl.xbyte(8'hff, 1'(i == n - 1), ack, rbuf[i]);
        ctl.stop();
    endtask : rd

    // compare the first n bytes read against ebuf
    task automatic rcmp(input int n);
        for (int i = 0; i < n; i++) chk_byte(rbuf[i], ebuf[i]);
    endtask : rcmp

    // one capture pulse carrying a time value
    task automatic cap(input logic up, input logic [7:0] m, input logic [7:0] h, input logic [7:0] d,
                       input logic [7:0] mo);
        @(posedge clock);
        {now_minutes, now_hours, now_date, now_month} <= {m, h, d, mo};
        capture_up <= up;
        capture_down <= !up;
        @(posedge clock);
        capture_up <= 1'b0;
        capture_down <= 1'b0;
    endtask : cap

    ////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            finish_test();
        end
    end

    // main sequence
    initial begin
        {rst_n, on_backup, capture_down, capture_up} = 4'h0;
        {now_minutes, now_hours, now_date, now_month} = 32'h0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk_bit(backup_input_enable, 1'b0);
        // sequential SRAM write across the block top, then read back
        for (int i = 0; i < 4; i++) wbuf[i] = 8'(8'h11 * (i + 1));
        for (int i = 0; i < 4; i++) ebuf[i] = wbuf[i];
        wr(8'h5e, 4);
        wr(8'h5e, 0);
        rd(3);
        rcmp(3);
        // single write, then the pointer sits just after it
        wbuf[0] = 8'h55;
        wr(8'h20, 1);
        rd(1);
        ebuf[0] = 8'h44;
        rcmp(1);
        // address past the SRAM: refused, nothing stored
        wbuf[0] = 8'h00;
        wr(8'h60, 1);
        // SRAM read, a power-down capture landing as the pointer-load write starts
        fork
            begin
                wr(8'h20, 0);
                rd(1);
            end
            cap(1'b0, 8'hd9, 8'h23, 8'hf1, 8'h52);
        join
        ebuf[0] = 8'h55;
        rcmp(1);
        chk_bit(power_fail_flag, 1'b1);
        // second down event is ignored, then power-up capture
        cap(1'b0, 8'h11, 8'h11, 8'h11, 8'h11);
        cap(1'b1, 8'h87, 8'hf1, 8'hc9, 8'he1);
        wr(8'h18, 0);
        rd(8);
        ebuf = '{0: 8'h59, 1: 8'h23, 2: 8'h31, 3: 8'h52, 4: 8'h07, 5: 8'h71, 6: 8'h09, 7: 8'he1, default: 8'h00};
        rcmp(8);
        // writing zero to the flag clears it and every stamp
        wbuf[0] = 8'h08;
        wr(8'h03, 1);
        chk_bit(power_fail_flag, 1'b0);
        chk_bit(backup_input_enable, 1'b1);
        // status reads back running oscillator, clear flag, backup enable
        wr(8'h03, 0);
        rd(1);
        ebuf[0] = 8'h28;
        rcmp(1);
        wr(8'h18, 0);
        rd(8);
        ebuf = '{default: 8'h00};
        rcmp(8);
        // stamp masks and register block wrap into offset 0
        for (int i = 0; i < 9; i++) wbuf[i] = (i == 8) ? 8'h5a : 8'hff;
        for (int i = 0; i < 9; i++) ebuf[i] = (i == 8) ? 8'h5a : (i % 4 == 2) ? 8'h3f : (i % 4 == 3) ? 8'hff : 8'h7f;
        wr(8'h18, 9);
        wr(8'h18, 0);
        rd(9);
        rcmp(9);
        // backup supply: control byte is not acknowledged
        on_backup <= 1'b1;
        repeat (6) @(posedge clock);
        ctl.start();
        ctl.xbyte({`CTRL_ADDR, 1'b0}, 1'b1, ack, rbuf[0]);
        chk_bit(ack, 1'b0);
        ctl.stop();
        on_backup <= 1'b0;
        // reset in mid-run: registers cleared, SRAM kept
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk_bit(backup_input_enable, 1'b0);
        wr(8'h5e, 0);
        rd(1);
        ebuf[0] = 8'h11;
        rcmp(1);
        finish_test();
    end
endmodule : rtcc_sram_i2c_access_tb

`default_nettype wire
